// File: shared/lps_pkg.sv
// Shared constants and types for the light and proximity sequencing block
package lps_pkg;

	localparam int CLK_HZ = 10_000_000;
	localparam int ALS_CONV_MS = 100;
	localparam int ALS_CONV_CYC = ALS_CONV_MS * (CLK_HZ / 1000);
	localparam int PROX_CONV_US = 540;
	localparam int PROX_CONV_CYC = PROX_CONV_US * (CLK_HZ / 1_000_000);
	localparam int LED_ON_US = 100;
	localparam int LED_ON_CYC = LED_ON_US * (CLK_HZ / 1_000_000);
	localparam int SLEEP_STEP_MS = 100;
	localparam int SLEEP_STEP_CYC = SLEEP_STEP_MS * (CLK_HZ / 1000);
	localparam int TMR_W = 24;
	localparam logic [11:0] ALS_FULL_SCALE = 12'hfff;
	localparam logic [7:0] PROX_FULL_SCALE = 8'hff;
	localparam logic [4:0] PERSIST_1 = 5'h01;
	localparam logic [4:0] PERSIST_4 = 5'h04;
	localparam logic [4:0] PERSIST_8 = 5'h08;
	localparam logic [4:0] PERSIST_16 = 5'h10;
	localparam logic RANGE_FINE = 1'h0;
	localparam logic CURRENT_110MA = 1'h0;

	typedef struct packed {
		logic ambient_conversion_enable;
		logic prox_enable;
		logic ambient_scale_select;
		logic led_current_select;
		logic [2:0] sleep_sel;
		logic [1:0] persist_sel;
		logic both_mode;
		logic [11:0] als_low_thr;
		logic [11:0] als_high_thr;
		logic [7:0] prox_thr;
	} lps_cfg_t;

	localparam lps_cfg_t CFG_RESET = '0;

	typedef struct packed {
		logic als_flag;
		logic prox_flag;
		logic power_down;
	} lps_status_t;

	typedef enum logic [1:0] {
		PX_IDLE = 2'b00,
		PX_LED = 2'b01,
		PX_CONV = 2'b10,
		PX_SLEEP = 2'b11
	} lps_prox_state_t;

endpackage : lps_pkg

// File: rtl/lps_ctrl.sv
// Conversion sequencing, persistence filter and interrupt for light/proximity sensing
`timescale 1ns/1ns
module lps_ctrl
	import lps_pkg::*;
#(
	parameter int ALS_CYC = ALS_CONV_CYC,
	parameter int PROX_CYC = PROX_CONV_CYC,
	parameter int LED_CYC = LED_ON_CYC,
	parameter int SLEEP_CYC = SLEEP_STEP_CYC
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic link_clk_in,
	input wire logic link_rst_n_in,
	input wire lps_cfg_t cfg_in,
	input wire logic cfg_wr_in,
	input wire logic flag_clr_in,
	input wire logic bus_address_select_pin_in,
	input wire logic [15:0] als_raw_in,
	input wire logic [7:0] prox_raw_in,
	output logic addr_lsb_out,
	output lps_status_t link_status_out,
	output lps_status_t status_out,
	output logic [11:0] als_result_out,
	output logic [7:0] prox_result_out,
	output logic als_convert_out,
	output logic prox_convert_out,
	output logic led_sink_pin_out,
	output logic led_current_select_out,
	output logic ambient_scale_select_out,
	output logic event_request_pin_out,
	output logic event_request_pin_oe_out
);

	////////////////////////////////////////////////////////////////////////////
	// Link domain: config capture, clear request, address pin, status view

	lps_cfg_t link_cfg_r;
	logic cfg_tgl_r;
	logic clr_tgl_r;
	logic [1:0] addr_sync_r;
	lps_status_t stat_s1_r;
	lps_status_t stat_s2_r;

	// Held config stays stable while the toggle crosses, so words are safe
	always_ff @(posedge link_clk_in or negedge link_rst_n_in) begin
		if (!link_rst_n_in) begin
			link_cfg_r <= CFG_RESET;
			cfg_tgl_r <= 1'b0;
		end else if (cfg_wr_in) begin
			link_cfg_r <= cfg_in;
			cfg_tgl_r <= ~cfg_tgl_r;
		end
	end

	always_ff @(posedge link_clk_in or negedge link_rst_n_in) begin
		if (!link_rst_n_in) begin
			clr_tgl_r <= 1'b0;
		end else if (flag_clr_in) begin
			clr_tgl_r <= ~clr_tgl_r;
		end
	end

	// Strap must be steady; two stages only guard against a slow edge
	always_ff @(posedge link_clk_in or negedge link_rst_n_in) begin
		if (!link_rst_n_in) begin
			addr_sync_r <= 2'h0;
			addr_lsb_out <= 1'b0;
		end else begin
			addr_sync_r <= {addr_sync_r[0], bus_address_select_pin_in};
			addr_lsb_out <= addr_sync_r[1];
		end
	end

	always_ff @(posedge link_clk_in or negedge link_rst_n_in) begin
		if (!link_rst_n_in) begin
			stat_s1_r <= '0;
			stat_s2_r <= '0;
			link_status_out <= '0;
		end else begin
			stat_s1_r <= status_out;
			stat_s2_r <= stat_s1_r;
			link_status_out <= stat_s2_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Core domain: receive config and clear events

	logic [2:0] cfg_sync_r;
	logic [2:0] clr_sync_r;
	lps_cfg_t cfg_r;
	logic cfg_load;
	logic clr_evt;

	assign cfg_load = cfg_sync_r[2] ^ cfg_sync_r[1];
	assign clr_evt = clr_sync_r[2] ^ clr_sync_r[1];

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_sync_r <= 3'h0;
			clr_sync_r <= 3'h0;
		end else begin
			cfg_sync_r <= {cfg_sync_r[1:0], cfg_tgl_r};
			clr_sync_r <= {clr_sync_r[1:0], clr_tgl_r};
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_r <= CFG_RESET;
		end else if (cfg_load) begin
			cfg_r <= link_cfg_r;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			led_current_select_out <= CURRENT_110MA;
			ambient_scale_select_out <= RANGE_FINE;
		end else begin
			led_current_select_out <= cfg_r.led_current_select;
			ambient_scale_select_out <= cfg_r.ambient_scale_select;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Ambient sequencer

	logic [TMR_W-1:0] als_tmr_r;
	logic als_done_r;
	logic als_active;

	assign als_active = cfg_r.ambient_conversion_enable;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			als_tmr_r <= '0;
			als_done_r <= 1'b0;
			als_convert_out <= 1'b0;
		end else if (!als_active) begin
			als_tmr_r <= '0;
			als_done_r <= 1'b0;
			als_convert_out <= 1'b0;
		end else if (als_tmr_r == TMR_W'(ALS_CYC - 1)) begin
			als_tmr_r <= '0;
			als_done_r <= 1'b1;
			als_convert_out <= 1'b1;
		end else begin
			als_tmr_r <= als_tmr_r + 1'b1;
			als_done_r <= 1'b0;
			als_convert_out <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			als_result_out <= '0;
		end else if (als_done_r) begin
			if (als_raw_in > 16'(ALS_FULL_SCALE)) begin
				als_result_out <= ALS_FULL_SCALE;
			end else begin
				als_result_out <= als_raw_in[11:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Proximity sequencer

	lps_prox_state_t px_state_r;
	logic [TMR_W-1:0] px_tmr_r;
	logic [TMR_W-1:0] sleep_cyc;
	logic px_done_r;

	// Sleep steps of one unit each, eight steps reach the longest interval
	assign sleep_cyc = TMR_W'(SLEEP_CYC) * TMR_W'({1'b0, cfg_r.sleep_sel} + 4'h1);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			px_state_r <= PX_IDLE;
			px_tmr_r <= '0;
			px_done_r <= 1'b0;
		end else if (!cfg_r.prox_enable) begin
			px_state_r <= PX_IDLE;
			px_tmr_r <= '0;
			px_done_r <= 1'b0;
		end else begin
			px_done_r <= 1'b0;
			px_tmr_r <= px_tmr_r + 1'b1;
			case (px_state_r)
				PX_IDLE: begin
					px_state_r <= PX_LED;
					px_tmr_r <= '0;
				end
				PX_LED: begin
					if (px_tmr_r == TMR_W'(LED_CYC - 1)) begin
						px_state_r <= PX_CONV;
					end
				end
				PX_CONV: begin
					if (px_tmr_r == TMR_W'(PROX_CYC - 1)) begin
						px_state_r <= PX_SLEEP;
						px_tmr_r <= '0;
						px_done_r <= 1'b1;
					end
				end
				PX_SLEEP: begin
					if (px_tmr_r == sleep_cyc - 1'b1) begin
						px_state_r <= PX_LED;
						px_tmr_r <= '0;
					end
				end
				default: begin
					px_state_r <= PX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			led_sink_pin_out <= 1'b0;
			prox_convert_out <= 1'b0;
		end else begin
			led_sink_pin_out <= cfg_r.prox_enable && px_state_r == PX_LED;
			prox_convert_out <= cfg_r.prox_enable &&
				(px_state_r == PX_LED || px_state_r == PX_CONV);
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prox_result_out <= '0;
		end else if (px_done_r) begin
			prox_result_out <= prox_raw_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trigger compare and persistence filter

	function automatic logic [4:0] persist_need(input logic [1:0] sel);
		case (sel)
			2'h0: persist_need = PERSIST_1;
			2'h1: persist_need = PERSIST_4;
			2'h2: persist_need = PERSIST_8;
			default: persist_need = PERSIST_16;
		endcase
	endfunction : persist_need

	// Compare on the stored result, one cycle after it loads
	logic als_eval_r;
	logic px_eval_r;
	logic als_trig;
	logic px_trig;
	logic [4:0] als_cnt_r;
	logic [4:0] px_cnt_r;
	logic als_hit;
	logic px_hit;

	assign als_trig = als_result_out < cfg_r.als_low_thr ||
		als_result_out > cfg_r.als_high_thr;
	assign px_trig = prox_result_out > cfg_r.prox_thr;
	assign als_hit = als_eval_r && als_trig && (als_cnt_r + 5'h1 >= persist_need(cfg_r.persist_sel));
	assign px_hit = px_eval_r && px_trig && (px_cnt_r + 5'h1 >= persist_need(cfg_r.persist_sel));

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			als_eval_r <= 1'b0;
			px_eval_r <= 1'b0;
		end else begin
			als_eval_r <= als_done_r;
			px_eval_r <= px_done_r;
		end
	end

	// Saturating count stays at the need so long runs keep re-firing
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			als_cnt_r <= '0;
		end else if (!als_active) begin
			als_cnt_r <= '0;
		end else if (als_eval_r) begin
			if (!als_trig) begin
				als_cnt_r <= '0;
			end else if (als_cnt_r < persist_need(cfg_r.persist_sel)) begin
				als_cnt_r <= als_cnt_r + 5'h1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			px_cnt_r <= '0;
		end else if (!cfg_r.prox_enable) begin
			px_cnt_r <= '0;
		end else if (px_eval_r) begin
			if (!px_trig) begin
				px_cnt_r <= '0;
			end else if (px_cnt_r < persist_need(cfg_r.persist_sel)) begin
				px_cnt_r <= px_cnt_r + 5'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flags, status and open-drain pin

	logic pin_assert;

	// A hit in the clearing cycle keeps its flag
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_out <= '0;
		end else begin
			status_out.power_down <= !cfg_r.ambient_conversion_enable &&
				!cfg_r.prox_enable;
			if (als_hit) begin
				status_out.als_flag <= 1'b1;
			end else if (clr_evt) begin
				status_out.als_flag <= 1'b0;
			end
			if (px_hit) begin
				status_out.prox_flag <= 1'b1;
			end else if (clr_evt) begin
				status_out.prox_flag <= 1'b0;
			end
		end
	end

	assign pin_assert = cfg_r.both_mode ?
		(status_out.als_flag && status_out.prox_flag) :
		(status_out.als_flag || status_out.prox_flag);

	// Output level is fixed low; only the enable moves
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			event_request_pin_out <= 1'b0;
			event_request_pin_oe_out <= 1'b0;
		end else begin
			event_request_pin_out <= 1'b0;
			event_request_pin_oe_out <= pin_assert;
		end
	end

endmodule : lps_ctrl

// File: testbench/lps_host_model.sv
// Host model: config writes and flag clears in the link domain
`timescale 1ns/1ns
module lps_host_model
	import lps_pkg::*;
(
	input wire logic link_clk_in,
	output lps_cfg_t cfg_out,
	output logic cfg_wr_out,
	output logic flag_clr_out
);
	initial begin
		cfg_out = CFG_RESET;
		cfg_wr_out = 1'b0;
		flag_clr_out = 1'b0;
	end
	////////////////////////////////////////
	// One-cycle pulse, then a long gap so the crossing never merges two
	task automatic send(input lps_cfg_t c, input logic clr);
		@(posedge link_clk_in);
		cfg_out <= c;
		cfg_wr_out <= !clr;
		flag_clr_out <= clr;
		@(posedge link_clk_in);
		cfg_wr_out <= 1'b0;
		flag_clr_out <= 1'b0;
		repeat (12) @(posedge link_clk_in);
	endtask : send
endmodule : lps_host_model

// File: testbench/lps_ctrl_sva.sv
// Checker for sequencing, results and interrupt pin
`timescale 1ns/1ns
module lps_ctrl_sva
	import lps_pkg::*;
#(
	parameter int LED_CYC = LED_ON_CYC
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire lps_status_t status_out,
	input wire logic [15:0] als_raw_in,
	input wire logic [7:0] prox_raw_in,
	input wire logic [11:0] als_result_out,
	input wire logic [7:0] prox_result_out,
	input wire logic als_convert_out,
	input wire logic prox_convert_out,
	input wire logic led_sink_pin_out,
	input wire logic event_request_pin_out,
	input wire logic event_request_pin_oe_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	int led_cnt_r;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			led_cnt_r <= 0;
		else
			led_cnt_r <= led_sink_pin_out ? led_cnt_r + 1 : 0;
	end
	////////////////////////////////////////
	property p_pin;
		event_request_pin_out == 1'b0;
	endproperty
	a_pin: assert property (p_pin) else $error("pin level not low");
	property p_oe;
		$rose(event_request_pin_oe_out) |-> $past(status_out.als_flag || status_out.prox_flag);
	endproperty
	a_oe: assert property (p_oe) else $error("pin pulled with no flag");
	property p_rel;
		!status_out.als_flag && !status_out.prox_flag |=> !event_request_pin_oe_out;
	endproperty
	a_rel: assert property (p_rel) else $error("pin not released");
	property p_pd;
		status_out.power_down && $past(status_out.power_down, 2) |-> !als_convert_out && !led_sink_pin_out;
	endproperty
	a_pd: assert property (p_pd) else $error("converting in power down");
	property p_led;
		$fell(led_sink_pin_out) |-> led_cnt_r == LED_CYC && prox_convert_out;
	endproperty
	a_led: assert property (p_led) else $error("led pulse length wrong");
	property p_conv;
		$rose(prox_convert_out) |-> prox_convert_out [*8];
	endproperty
	a_conv: assert property (p_conv) else $error("prox conversion too short");
	property p_sat;
		$changed(als_result_out) |->
			als_result_out == ($past(als_raw_in) > 16'h0fff ? 12'hfff : $past(als_raw_in[11:0]));
	endproperty
	a_sat: assert property (p_sat) else $error("ambient result wrong");
	property p_prox;
		$changed(prox_result_out) |-> prox_result_out == $past(prox_raw_in);
	endproperty
	a_prox: assert property (p_prox) else $error("prox result wrong");
	c_oe: cover property ($rose(event_request_pin_oe_out));
	c_led: cover property ($fell(led_sink_pin_out));
	c_sat: cover property (als_result_out == ALS_FULL_SCALE);
endmodule : lps_ctrl_sva
bind lps_ctrl lps_ctrl_sva #(.LED_CYC(LED_CYC)) u_sva (.clk_in, .rst_n_in, .status_out,
	.als_raw_in, .prox_raw_in, .als_result_out, .prox_result_out, .als_convert_out,
	.prox_convert_out, .led_sink_pin_out, .event_request_pin_out, .event_request_pin_oe_out);

// File: testbench/tb_top.sv
// Testbench: window, persistence, pin and power-down checks
`timescale 1ns/1ns
module tb_top;
	import lps_pkg::*;
	logic clk_in = 0, rst_n_in = 0, link_clk_in = 0, link_rst_n_in = 0;
	logic cfg_wr_in, flag_clr_in, bus_address_select_pin_in = 0;
	lps_cfg_t cfg_in, cfg;
	logic [15:0] als_raw_in = 16'h0;
	logic [7:0] prox_raw_in = 8'h0;
	logic addr_lsb_out, als_convert_out, prox_convert_out, led_sink_pin_out;
	logic led_current_select_out, ambient_scale_select_out;
	logic event_request_pin_out, event_request_pin_oe_out;
	lps_status_t link_status_out, status_out;
	logic [11:0] als_result_out, old;
	logic [7:0] prox_result_out;
	int num_errors = 0, total_checks = 0, cycles = 0, cnt, need[4] = '{1, 4, 8, 16};
	logic [31:0] lfsr = 32'hf6ffcb30;
	logic flag_m;
	logic [15:0] araw[3] = '{16'h0050, 16'h1234, 16'h0800};
	logic [11:0] ares[3] = '{12'h050, 12'hfff, 12'h800};
	logic afl[3] = '{1'b1, 1'b1, 1'b0};
	always #50 clk_in = ~clk_in;
	initial begin
		#17;
		forever #40 link_clk_in = ~link_clk_in;
	end
	lps_ctrl #(.ALS_CYC(50), .PROX_CYC(20), .LED_CYC(5), .SLEEP_CYC(30)) dut (.*);
	lps_host_model host (.link_clk_in, .cfg_out(cfg_in), .cfg_wr_out(cfg_wr_in),
		.flag_clr_out(flag_clr_in));
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt
	task automatic wait_cv(input logic v);
		for (int k = 0; k < 400 && prox_convert_out !== v; k++)
			@(negedge clk_in);
	endtask : wait_cv
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			end_sim();
		end
	end
	////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		link_rst_n_in <= 1'b1;
		cfg = CFG_RESET;
		cfg.ambient_conversion_enable = 1'b1;
		cfg.als_low_thr = 12'h100;
		cfg.als_high_thr = 12'he00;
		als_raw_in <= araw[0];
		host.send(cfg, 1'b0);
		for (int i = 0; i < 3; i++) begin
			old = als_result_out;
			for (int k = 0; k < 200 && als_result_out === old; k++)
				@(negedge clk_in);
			repeat (3) @(negedge clk_in);
			chk("als", als_result_out, ares[i]);
			chk("aflag", status_out.als_flag, afl[i]);
			chk("aoe", event_request_pin_oe_out, afl[i]);
			host.send(cfg, 1'b1);
			@(posedge clk_in);
			als_raw_in <= araw[(i + 1) % 3];
		end
		for (int s = 0; s < 4; s++) begin
			host.send(CFG_RESET, 1'b0);
			host.send(CFG_RESET, 1'b1);
			@(posedge clk_in);
			bus_address_select_pin_in <= s[0];
			cfg = CFG_RESET;
			cfg.prox_enable = 1'b1;
			// Pass 0 runs both sources in coincidence mode; ambient raw sits below the window
			cfg.ambient_conversion_enable = (s == 0);
			cfg.both_mode = (s == 0);
			cfg.als_low_thr = 12'h100;
			cfg.als_high_thr = 12'he00;
			cfg.sleep_sel = 3'(s);
			cfg.persist_sel = s[1:0];
			cfg.led_current_select = s[0];
			cfg.ambient_scale_select = s[1];
			cfg.prox_thr = 8'h80;
			host.send(cfg, 1'b0);
			@(negedge clk_in);
			chk("cur", led_current_select_out, s[0]);
			chk("scale", ambient_scale_select_out, s[1]);
			chk("addr", addr_lsb_out, s[0]);
			cnt = 0;
			flag_m = 1'b0;
			for (int k = 0; k < 20; k++) begin
				wait_cv(1'b1);
				wait_cv(1'b0);
				repeat (3) @(negedge clk_in);
				chk("prox", prox_result_out, prox_raw_in);
				cnt = prox_raw_in > 8'h80 ? cnt + 1 : 0;
				flag_m |= cnt >= need[s];
				chk("pflag", status_out.prox_flag, flag_m);
				// Ambient flag lands between the first and second proximity result
				chk("bflag", status_out.als_flag, s == 0 && k > 0);
				chk("poe", event_request_pin_oe_out, s == 0 ? flag_m && k > 0 : flag_m);
				lfsr = nxt(lfsr);
				@(posedge clk_in);
				// Boundary value 8'h80 shows up on purpose
				prox_raw_in <= lfsr[3:0] != 4'h0 ? {1'b1, lfsr[10:4]} : lfsr[11:4];
			end
			repeat (8) @(negedge clk_in);
			chk("lstat", link_status_out, status_out);
		end
		host.send(CFG_RESET, 1'b0);
		repeat (4) @(negedge clk_in);
		chk("pd", status_out.power_down, 1'b1);
		chk("pdcv", prox_convert_out, 1'b0);
		end_sim();
	end
endmodule : tb_top
